// file: include/lbsb_pkg.sv
// Purpose: Shared constants for the LCD bit-set and busy-flag link.
// Assumes: One 100 MHz clock shared by both ends of the link.
// Notes: Instruction codes select what the next data transfer does.
package lbsb_pkg;
  localparam int unsigned LBSB_CLK_NS = 10;
  localparam int unsigned LBSB_EXEC_NS = 40;
  localparam int unsigned LBSB_EXEC_CYCLES_DEF = (LBSB_EXEC_NS + LBSB_CLK_NS - 1) / LBSB_CLK_NS;
  localparam int unsigned LBSB_RAM_BYTES_DEF = 8192;
  localparam logic [7:0] LBSB_IC_MODE = 8'h00;
  localparam logic [7:0] LBSB_IC_PITCH = 8'h01;
  localparam logic [7:0] LBSB_IC_CHARS = 8'h02;
  localparam logic [7:0] LBSB_IC_LINES = 8'h03;
  localparam logic [7:0] LBSB_IC_CURLINE = 8'h04;
  localparam logic [7:0] LBSB_IC_START_LO = 8'h08;
  localparam logic [7:0] LBSB_IC_START_HI = 8'h09;
  localparam logic [7:0] LBSB_IC_CUR_LO = 8'h0A;
  localparam logic [7:0] LBSB_IC_CUR_HI = 8'h0B;
  localparam logic [7:0] LBSB_IC_WRITE = 8'h0C;
  localparam logic [7:0] LBSB_IC_READ = 8'h0D;
  localparam logic [7:0] LBSB_IC_BIT_CLR = 8'h0E;
  localparam logic [7:0] LBSB_IC_BIT_SET = 8'h0F;
  localparam int unsigned LBSB_BUSY_BIT = 7;
  localparam logic [2:0] LBSB_HP_MIN_M1 = 3'h5;
  localparam logic [3:0] LBSB_HP_RST = 4'h7;
  localparam logic [3:0] LBSB_VP_RST = 4'h7;
  localparam logic [7:0] LBSB_NX_RST = 8'h9F;
  localparam logic [7:0] LBSB_HN_RST = 8'h13;
  localparam logic [7:0] LBSB_PADDR_CMD = 8'h00;
  localparam logic [7:0] LBSB_PADDR_STATUS = 8'h04;
  localparam logic [7:0] LBSB_PADDR_RDATA = 8'h08;
  localparam int unsigned LBSB_CMD_RS_BIT = 8;
  localparam int unsigned LBSB_CMD_RW_BIT = 9;
endpackage

// file: include/lbsb_if.sv
// Purpose: Parallel link between the LCD controller and its host.
// Assumes: Both ends run on pclk; strobe is a one-cycle pulse.
// Notes: The data bus idles high when nobody drives it.
`timescale 1ns/1ps
`default_nettype none
interface lbsb_if;
  logic strb;
  logic register_select;
  logic rw;
  logic [7:0] h_dq_o;
  logic h_dq_oe_n;
  logic [7:0] d_dq_o;
  logic d_dq_oe_n;
  logic [7:0] dq;
  assign dq = !h_dq_oe_n ? h_dq_o : (!d_dq_oe_n ? d_dq_o : 8'hFF);
  modport host (output strb, output register_select, output rw, output h_dq_o, output h_dq_oe_n, input dq);
  modport device (input strb, input register_select, input rw, input dq, output d_dq_o, output d_dq_oe_n);
endinterface
`default_nettype wire

// file: rtl/lbsb_device.sv
// Purpose: LCD controller instruction handling for bit set, bit clear and busy flag.
// Assumes: Host strobes the link for one pclk cycle per access.
// Notes: Execution time is a parameter; geometry values are stored minus one.
`timescale 1ns/1ps
`default_nettype none
module lbsb_device
  import lbsb_pkg::*;
#(
  parameter int unsigned RAM_BYTES = LBSB_RAM_BYTES_DEF,
  parameter int unsigned EXEC_CYCLES = LBSB_EXEC_CYCLES_DEF
)
(
  input wire logic pclk,
  input wire logic presetn,
  lbsb_if.device lnk,
  output logic busy,
  output logic [15:0] cursor_addr,
  output logic [15:0] start_addr,
  output logic [7:0] display_mode,
  output logic [3:0] horizontal_char_pitch,
  output logic [8:0] chars_per_line,
  output logic [4:0] vertical_char_pitch,
  output logic [4:0] cursor_line,
  output logic [8:0] line_count,
  output logic cursor_visible,
  output logic [11:0] horizontal_dots,
  output logic [8:0] text_rows
);
  localparam int unsigned AW = $clog2(RAM_BYTES);
  localparam logic [15:0] EXEC_LAST = 16'(EXEC_CYCLES - 1);

  typedef struct packed {
    logic [7:0] ir;
    logic busy;
    logic inc;
    logic [15:0] cnt;
    logic [15:0] cursor;
    logic [15:0] start;
    logic [7:0] dout;
    logic [7:0] rd_data;
    logic rd_oe;
    logic [7:0] mode;
    logic [2:0] hp;
    logic [3:0] vp;
    logic [7:0] hn;
    logic [3:0] cp;
    logic [7:0] nx;
    logic vis;
    logic [11:0] hdots;
    logic [8:0] rows;
    logic [3:0] o_hp;
    logic [8:0] o_hn;
    logic [4:0] o_vp;
    logic [4:0] o_cp;
    logic [8:0] o_nx;
  } lbsb_dev_t;

  lbsb_dev_t s_r;
  lbsb_dev_t s_nxt;
  logic [7:0] ram [RAM_BYTES];
  logic [7:0] ram_rd;
  logic ram_we;
  logic [7:0] ram_wd;
  logic [7:0] bit_mask;

  assign ram_rd = ram[s_r.cursor[AW-1:0]];

  always_comb
  begin
    s_nxt = s_r;
    ram_we = 1'b0;
    ram_wd = ram_rd;
    bit_mask = 8'h01 << lnk.dq[2:0];
    s_nxt.rd_oe = 1'b0;
    s_nxt.vis = ({1'b0, s_r.cp} <= {1'b0, s_r.vp});
    s_nxt.hdots = 12'(({9'h000, s_r.hp} + 12'h001) * ({4'h0, s_r.hn} + 12'h001));
    s_nxt.rows = 9'(({1'b0, s_r.nx} + 9'h001) / ({5'h00, s_r.vp} + 9'h001));
    if (s_r.busy)
    begin
      if (s_r.cnt == 16'h0000)
      begin
        s_nxt.busy = 1'b0;
        s_nxt.inc = 1'b0;
        if (s_r.inc)
        begin
          s_nxt.cursor = s_r.cursor + 16'h0001;
        end
      end
      else
      begin
        s_nxt.cnt = s_r.cnt - 16'h0001;
      end
    end
    if (lnk.strb)
    begin
      if (lnk.rw)
      begin
        s_nxt.rd_oe = 1'b1;
        if (lnk.register_select)
        begin
          // Low bits read zero; their content carries no meaning.
          s_nxt.rd_data = 8'(s_r.busy) << LBSB_BUSY_BIT;
        end
        else
        begin
          s_nxt.rd_data = s_r.dout;
          if (!s_r.busy && s_r.ir == LBSB_IC_READ)
          begin
            // The output register lags one read behind; a dummy read is needed first.
            s_nxt.dout = ram_rd;
            s_nxt.busy = 1'b1;
            s_nxt.inc = 1'b1;
            s_nxt.cnt = EXEC_LAST;
          end
        end
      end
      else if (!s_r.busy)
      begin
        if (lnk.register_select)
        begin
          s_nxt.ir = lnk.dq;
        end
        else
        begin
          s_nxt.busy = 1'b1;
          s_nxt.cnt = EXEC_LAST;
          unique case (s_r.ir)
            LBSB_IC_MODE: s_nxt.mode = lnk.dq;
            LBSB_IC_PITCH:
            begin
              // Horizontal pitches below six dots are raised to six so the glyph always fits; vertical pitch is stored as written.
              s_nxt.hp = (lnk.dq[2:0] < LBSB_HP_MIN_M1) ? LBSB_HP_MIN_M1 : lnk.dq[2:0];
              s_nxt.vp = lnk.dq[7:4];
            end
            LBSB_IC_CHARS: s_nxt.hn = lnk.dq;
            LBSB_IC_LINES: s_nxt.nx = lnk.dq;
            LBSB_IC_CURLINE: s_nxt.cp = lnk.dq[3:0];
            LBSB_IC_START_LO: s_nxt.start[7:0] = lnk.dq;
            LBSB_IC_START_HI: s_nxt.start[15:8] = lnk.dq;
            LBSB_IC_CUR_LO: s_nxt.cursor[7:0] = lnk.dq;
            LBSB_IC_CUR_HI: s_nxt.cursor[15:8] = lnk.dq;
            LBSB_IC_WRITE:
            begin
              ram_we = 1'b1;
              ram_wd = lnk.dq;
              s_nxt.inc = 1'b1;
            end
            LBSB_IC_BIT_CLR:
            begin
              ram_we = 1'b1;
              ram_wd = ram_rd & ~bit_mask;
              s_nxt.inc = 1'b1;
            end
            LBSB_IC_BIT_SET:
            begin
              ram_we = 1'b1;
              ram_wd = ram_rd | bit_mask;
              s_nxt.inc = 1'b1;
            end
            default: s_nxt.inc = 1'b0;
          endcase
        end
      end
    end
    // The plus-one values are registered so no adder ripple reaches the pins.
    s_nxt.o_hp = {1'b0, s_nxt.hp} + 4'h1;
    s_nxt.o_hn = {1'b0, s_nxt.hn} + 9'h001;
    s_nxt.o_vp = {1'b0, s_nxt.vp} + 5'h01;
    s_nxt.o_cp = {1'b0, s_nxt.cp} + 5'h01;
    s_nxt.o_nx = {1'b0, s_nxt.nx} + 9'h001;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.hp <= LBSB_HP_RST[2:0];
      s_r.vp <= LBSB_VP_RST;
      s_r.hn <= LBSB_HN_RST;
      s_r.nx <= LBSB_NX_RST;
      s_r.o_hp <= {1'b0, LBSB_HP_RST[2:0]} + 4'h1;
      s_r.o_hn <= {1'b0, LBSB_HN_RST} + 9'h001;
      s_r.o_vp <= {1'b0, LBSB_VP_RST} + 5'h01;
      s_r.o_cp <= 5'h01;
      s_r.o_nx <= {1'b0, LBSB_NX_RST} + 9'h001;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // The RAM is kept outside the state struct so it can map to a memory macro.
  always_ff @(posedge pclk)
  begin
    if (ram_we)
    begin
      ram[s_r.cursor[AW-1:0]] <= ram_wd;
    end
  end

  assign lnk.d_dq_o = s_r.rd_data;
  assign lnk.d_dq_oe_n = !s_r.rd_oe;
  assign busy = s_r.busy;
  assign cursor_addr = s_r.cursor;
  assign start_addr = s_r.start;
  assign display_mode = s_r.mode;
  assign horizontal_char_pitch = s_r.o_hp;
  assign chars_per_line = s_r.o_hn;
  assign vertical_char_pitch = s_r.o_vp;
  assign cursor_line = s_r.o_cp;
  assign line_count = s_r.o_nx;
  assign cursor_visible = s_r.vis;
  assign horizontal_dots = s_r.hdots;
  assign text_rows = s_r.rows;
endmodule // lbsb_device
`default_nettype wire

// file: rtl/lbsb_host.sv
// Purpose: Host end that runs link accesses ordered by software over APB.
// Assumes: Software writes one command and waits until pending clears.
// Notes: Every access except a status read is preceded by a busy poll.
`timescale 1ns/1ps
`default_nettype none
module lbsb_host
  import lbsb_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  lbsb_if.host lnk
);
  typedef enum logic [2:0] {H_IDLE, H_POLL, H_PWAIT, H_XFER, H_XWAIT} lbsb_hst_t;

  typedef struct packed {
    lbsb_hst_t st;
    logic pend;
    logic [7:0] data;
    logic rs;
    logic rw;
    logic strb;
    logic lrs;
    logic lrw;
    logic [7:0] dq_o;
    logic oe_n;
    logic [7:0] rdata;
    logic rvalid;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } lbsb_host_t;

  lbsb_host_t s_r;
  lbsb_host_t s_nxt;
  logic acc;
  logic mapped;

  assign acc = psel && penable && s_r.pready;
  assign mapped = (paddr == LBSB_PADDR_CMD) || (paddr == LBSB_PADDR_STATUS) || (paddr == LBSB_PADDR_RDATA);

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.pready = psel && !penable;
    if (psel && !penable)
    begin
      s_nxt.pslverr = !mapped;
      s_nxt.prdata = 32'h0000_0000;
      if (paddr == LBSB_PADDR_STATUS)
      begin
        s_nxt.prdata = {30'h0000_0000, s_r.rvalid, s_r.pend};
      end
      else if (paddr == LBSB_PADDR_RDATA)
      begin
        s_nxt.prdata = {24'h00_0000, s_r.rdata};
      end
    end
    unique case (s_r.st)
      H_IDLE:
      begin
        // A command written while one is pending is dropped, so the first one stays intact.
        if (acc && pwrite && paddr == LBSB_PADDR_CMD && !s_r.pend)
        begin
          s_nxt.pend = 1'b1;
          s_nxt.data = pwdata[7:0];
          s_nxt.rs = pwdata[LBSB_CMD_RS_BIT];
          s_nxt.rw = pwdata[LBSB_CMD_RW_BIT];
          s_nxt.strb = 1'b1;
          if (pwdata[LBSB_CMD_RS_BIT] && pwdata[LBSB_CMD_RW_BIT])
          begin
            s_nxt.st = H_XFER;
            s_nxt.lrs = 1'b1;
            s_nxt.lrw = 1'b1;
            s_nxt.rvalid = 1'b0;
          end
          else
          begin
            s_nxt.st = H_POLL;
            s_nxt.lrs = 1'b1;
            s_nxt.lrw = 1'b1;
          end
        end
      end
      H_POLL:
      begin
        s_nxt.strb = 1'b0;
        s_nxt.st = H_PWAIT;
      end
      H_PWAIT:
      begin
        s_nxt.strb = 1'b1;
        // Polling always, rather than timing a skip, costs a few cycles but never races.
        if (lnk.dq[LBSB_BUSY_BIT])
        begin
          s_nxt.st = H_POLL;
        end
        else
        begin
          s_nxt.st = H_XFER;
          s_nxt.lrs = s_r.rs;
          s_nxt.lrw = s_r.rw;
          s_nxt.dq_o = s_r.data;
          s_nxt.oe_n = s_r.rw;
          s_nxt.rvalid = 1'b0;
        end
      end
      H_XFER:
      begin
        s_nxt.strb = 1'b0;
        s_nxt.st = H_XWAIT;
      end
      H_XWAIT:
      begin
        s_nxt.oe_n = 1'b1;
        s_nxt.pend = 1'b0;
        s_nxt.st = H_IDLE;
        if (s_r.lrw)
        begin
          s_nxt.rdata = lnk.dq;
          s_nxt.rvalid = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r <= '0;
      s_r.st <= H_IDLE;
      s_r.oe_n <= 1'b1;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.prdata;
  assign pready = s_r.pready;
  assign pslverr = s_r.pslverr;
  assign lnk.strb = s_r.strb;
  assign lnk.register_select = s_r.lrs;
  assign lnk.rw = s_r.lrw;
  assign lnk.h_dq_o = s_r.dq_o;
  assign lnk.h_dq_oe_n = s_r.oe_n;
endmodule // lbsb_host
`default_nettype wire

// file: sim/lbsb_assertions.sv
// Purpose: Protocol checks on the link between host and LCD controller.
// Assumes: One clock, asynchronous active-low reset.
// Notes: Busy length is counted in helper logic, since a repetition cannot hold it.
`timescale 1ns/1ps
`default_nettype none
module lbsb_assertions
#(
  parameter int unsigned EXEC_CYCLES = 4
)
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic strb,
  input wire logic register_select,
  input wire logic rw,
  input wire logic h_dq_oe_n,
  input wire logic d_dq_oe_n,
  input wire logic [7:0] d_dq_o,
  input wire logic busy
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  int unsigned run_r;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_r <= 0;
    else
      run_r <= busy ? run_r + 1 : 0;
  end
  property p_stat; strb && register_select && rw |=> !d_dq_oe_n && d_dq_o == {$past(busy), 7'h00}; endproperty
  a_stat: assert property (p_stat) else $error("status byte wrong");
  property p_busy_on; strb && !register_select && !busy |=> busy; endproperty
  a_busy_on: assert property (p_busy_on) else $error("busy did not rise");
  property p_busy_len; $fell(busy) |-> run_r == EXEC_CYCLES; endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
  property p_ir_quiet; strb && register_select && !rw && !busy |=> !busy; endproperty
  a_ir_quiet: assert property (p_ir_quiet) else $error("instruction write set busy");
  property p_poll; strb && !(register_select && rw) |-> !busy; endproperty
  a_poll: assert property (p_poll) else $error("access while busy");
  property p_answer; strb && rw |=> !d_dq_oe_n; endproperty
  a_answer: assert property (p_answer) else $error("no read answer");
  property p_one; !d_dq_oe_n |=> d_dq_oe_n; endproperty
  a_one: assert property (p_one) else $error("read drive too long");
  property p_hdrive; strb && !rw |-> !h_dq_oe_n; endproperty
  a_hdrive: assert property (p_hdrive) else $error("host not driving write");
  cover property (strb && register_select && rw && busy);
  cover property ($fell(busy));
  cover property (strb && !register_select && rw);
endmodule // lbsb_assertions
`default_nettype wire

// file: sim/tb_top.sv
// Purpose: Self-checking bench for host and controller joined by the link.
// Assumes: Software side is driven over APB by the bench.
// Notes: Execution is lengthened so a status read lands inside busy.
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import lbsb_pkg::*;
();
  localparam int unsigned EXEC = 20;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic busy, cursor_visible, er;
  logic [15:0] cursor_addr, start_addr;
  logic [7:0] display_mode;
  logic [3:0] hp;
  logic [4:0] vp, cl;
  logic [8:0] cpl, lc, rows;
  logic [11:0] hdots;
  int err_count = 0, n_tests = 0;
  typedef struct {logic [7:0] ic; logic [7:0] dat; int k; logic [15:0] exp;} lbsb_row_t;
  lbsb_row_t rows_t[11] = '{'{LBSB_IC_PITCH, 8'hF5, 0, 16'h00D0}, '{LBSB_IC_CHARS, 8'h09, 1, 16'h003C},
    '{LBSB_IC_LINES, 8'h4F, 2, 16'h0005}, '{LBSB_IC_CURLINE, 8'h0F, 3, 16'h0030},
    '{LBSB_IC_PITCH, 8'h72, 3, 16'h0010}, '{LBSB_IC_PITCH, 8'h07, 0, 16'h0101},
    '{LBSB_IC_LINES, 8'hFF, 4, 16'h0100}, '{LBSB_IC_CHARS, 8'hFF, 1, 16'h0800},
    '{LBSB_IC_MODE, 8'h3C, 5, 16'h003C}, '{LBSB_IC_START_LO, 8'h34, 6, 16'h0034},
    '{LBSB_IC_START_HI, 8'h12, 6, 16'h1234}};
  always #5 pclk = ~pclk;
  lbsb_if i_lbsb_if();
  lbsb_host i_lbsb_host(.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(i_lbsb_if));
  lbsb_device #(.RAM_BYTES(256), .EXEC_CYCLES(EXEC)) i_lbsb_device(.pclk(pclk), .presetn(presetn),
    .lnk(i_lbsb_if), .busy(busy), .cursor_addr(cursor_addr), .start_addr(start_addr), .display_mode(display_mode),
    .horizontal_char_pitch(hp), .chars_per_line(cpl), .vertical_char_pitch(vp), .cursor_line(cl),
    .line_count(lc), .cursor_visible(cursor_visible), .horizontal_dots(hdots), .text_rows(rows));
  lbsb_assertions #(.EXEC_CYCLES(EXEC)) i_lbsb_assertions(.pclk(pclk), .presetn(presetn),
    .strb(i_lbsb_if.strb), .register_select(i_lbsb_if.register_select), .rw(i_lbsb_if.rw),
    .h_dq_oe_n(i_lbsb_if.h_dq_oe_n), .d_dq_oe_n(i_lbsb_if.d_dq_oe_n), .d_dq_o(i_lbsb_if.d_dq_o), .busy(busy));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      err_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic print_verdict();
    $display("errors=%0d checks=%0d", err_count, n_tests);
    if (err_count == 0 && n_tests > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // The master holds every field until pready is sampled high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Only the watchdog ends a wait for the slave.
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic cmd(input logic r, input logic s, input logic [7:0] d);
    int n;
    apb(1'b1, LBSB_PADDR_CMD, {22'h0, r, s, d});
    n = 0;
    rd = 32'h1;
    while (rd[0] !== 1'b0 && n < 200)
    begin
      apb(1'b0, LBSB_PADDR_STATUS, 32'h0);
      n++;
    end
    if (rd[0] !== 1'b0)
      err_count++;
  endtask
  task automatic pair(input logic [7:0] ic, input logic [7:0] d);
    int n;
    cmd(1'b0, 1'b1, ic);
    cmd(1'b0, 1'b0, d);
    n = 0;
    while (busy !== 1'b0 && n < 100)
    begin
      @(posedge pclk);
      n++;
    end
    if (busy !== 1'b0)
      err_count++;
    repeat (2) @(posedge pclk);
  endtask
  task automatic set_cur();
    pair(LBSB_IC_CUR_LO, 8'h10);
    pair(LBSB_IC_CUR_HI, 8'h00);
  endtask
  function automatic logic [15:0] obs(int k);
    case (k)
      0: return {7'h00, hp, vp};
      1: return {4'h0, hdots};
      2: return {7'h00, rows};
      3: return {10'h000, cursor_visible, cl};
      4: return {7'h00, lc};
      5: return {8'h00, display_mode};
      default: return start_addr;
    endcase
  endfunction
  initial
  begin
    repeat (16) @(posedge pclk);
    chk({hp, vp, cl, lc, cpl}, {4'h8, 5'h08, 5'h01, 9'h0A0, 9'h014});
    chk({31'h0, busy}, 32'h0);
    presetn <= 1'b1;
    foreach (rows_t[i])
    begin
      pair(rows_t[i].ic, rows_t[i].dat);
      chk({16'h0, obs(rows_t[i].k)}, {16'h0, rows_t[i].exp});
    end
    set_cur();
    chk({16'h0, cursor_addr}, 32'h10);
    pair(LBSB_IC_WRITE, 8'hA5);
    chk({16'h0, cursor_addr}, 32'h11);
    set_cur();
    pair(LBSB_IC_BIT_SET, 8'h01);
    chk({16'h0, cursor_addr}, 32'h11);
    set_cur();
    pair(LBSB_IC_BIT_CLR, 8'h07);
    set_cur();
    pair(LBSB_IC_READ, 8'h00);
    // The first data read only primes the output register.
    cmd(1'b1, 1'b0, 8'h00);
    cmd(1'b1, 1'b0, 8'h00);
    apb(1'b0, LBSB_PADDR_RDATA, 32'h0);
    chk(rd, 32'h27);
    pair(LBSB_IC_WRITE, 8'h5A);
    cmd(1'b1, 1'b1, 8'h00);
    apb(1'b0, LBSB_PADDR_RDATA, 32'h0);
    chk({rd[31:8], rd[7], 7'h00}, 32'h0);
    cmd(1'b0, 1'b1, LBSB_IC_WRITE);
    cmd(1'b0, 1'b0, 8'h3C);
    cmd(1'b1, 1'b1, 8'h00);
    apb(1'b0, LBSB_PADDR_RDATA, 32'h0);
    chk(rd, 32'h80);
    repeat (30) @(posedge pclk);
    cmd(1'b1, 1'b1, 8'h00);
    apb(1'b0, LBSB_PADDR_RDATA, 32'h0);
    chk(rd, 32'h00);
    apb(1'b0, 8'h0C, 32'h0);
    chk({31'h0, er}, 32'h1);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk({hp, vp, cl, lc, cpl}, {4'h8, 5'h08, 5'h01, 9'h0A0, 9'h014});
    chk({16'h0, cursor_addr}, 32'h0);
    presetn <= 1'b1;
    pair(LBSB_IC_CHARS, 8'h09);
    chk({20'h0, hdots}, 32'h50);
    print_verdict();
  end
  initial
  begin
    #400000;
    err_count++;
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
